/* File: tb.sv */
// self-checking bench for the usb event control block
`timescale 1ns/1ns
module tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic sfull = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] odd = 2'h2;
  logic [31:0] prdata, rdq;
  logic [7:0] ep;
  logic [1:0] pull_en;
  logic pready, pslverr, errq, reg_en, tie_hi, usb_md, oe_a_n, oe_b_n, clk_en, cur_red;
  logic cpu_rst, rwake, wake_cpu, usb_irq, irq, bre, sus, res;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int wake_n = 0;
  always #50 clk = ~clk;
  usb_sie_event_control dut
  (
    .I_CLOCK(clk),
    .I_SYS_RST(rst),
    .I_CE(ce),
    .I_PSEL(psel),
    .I_PENABLE(pen),
    .I_PWRITE(pwr),
    .I_PADDR(paddr),
    .I_PWDATA(pwdata),
    .O_PRDATA(prdata),
    .O_PREADY(pready),
    .O_PSLVERR(pslverr),
    .I_EP_ACCESS(ep),
    .I_BUS_RESET_DET(bre),
    .I_SUSPEND_DET(sus),
    .I_RESUME_DET(res),
    .I_STACK_FULL(sfull),
    .I_OD_DATA(odd),
    .O_REG_EN(reg_en),
    .O_REG_TIE_HIGH(tie_hi),
    .O_USB_MODE(usb_md),
    .O_OD_A_OE_N(oe_a_n),
    .O_OD_B_OE_N(oe_b_n),
    .O_PULLUP_EN(pull_en),
    .O_USB_CLK_EN(clk_en),
    .O_SUSPEND_FLAG_CUR_REDUCE(cur_red),
    .O_CPU_RESET(cpu_rst),
    .O_REMOTE_WAKE(rwake),
    .O_WAKE_CPU(wake_cpu),
    .O_USB_IRQ(usb_irq),
    .O_IRQ(irq)
  );
  usb_host_model hm
  (
    .i_clk(clk),
    .o_ep_access(ep),
    .o_bus_reset(bre),
    .o_suspend(sus),
    .o_resume(res)
  );
  // request stands until ready is sampled high at a rising edge; data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
      $display("BAD %0t got %h exp %h", $time, g, e);
    if (g !== e)
      bad_count++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rdq, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(negedge clk)
    if (rwake === 1'h1)
      wake_n++;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      end_sim;
    end
  end
  initial
  begin
    wt(5);
    rst <= 1'h0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h80);
    rd(8'h08, 32'h0);
    rd(8'h18, 32'h0);
    chk(errq, 32'h1);
    $display("reset values done");
    for (int m = 0; m < 8; m++)
    begin
      bus(1'h1, 8'h04, 32'h80 | (m << 4));
      wt(2);
      chk({reg_en, tie_hi, usb_md, oe_a_n, oe_b_n, pull_en},
          {m[2:1] == 2'h1, m == 1, m[2:1] == 2'h1, m != 1, 1'h1, m == 1, m == 1});
    end
    $display("pin modes done");
    bus(1'h1, 8'h04, 32'h90);
    bus(1'h1, 8'h14, 32'hF);
    bus(1'h1, 8'h00, 32'h1);
    hm.hit(1);
    wt(3);
    chk(usb_irq, 32'h0);
    sfull <= 1'h1;
    hm.hit(0);
    wt(3);
    chk(usb_irq, 32'h0);
    rd(8'h08, 32'h3);
    sfull <= 1'h0;
    wt(3);
    chk({usb_irq, irq}, 32'h3);
    rd(8'h10, 32'h1);
    wt(1);
    chk(irq, 32'h0);
    bus(1'h1, 8'h14, 32'h0);
    hm.hit(0);
    wt(3);
    chk(irq, 32'h0);
    bus(1'h1, 8'h08, 32'h0);
    wt(2);
    chk(usb_irq, 32'h0);
    // an access while the enable is low must leave no flag behind
    ce <= 1'h0;
    hm.hit(2);
    ce <= 1'h1;
    rd(8'h08, 32'h0);
    $display("endpoint irq done");
    hm.lvl(0, 1'h1);
    wt(3);
    chk({cpu_rst, usb_irq}, 32'h3);
    rd(8'h04, 32'h94);
    hm.lvl(0, 1'h0);
    wt(3);
    bus(1'h1, 8'h04, 32'h14);
    hm.lvl(0, 1'h1);
    wt(3);
    chk(cpu_rst, 32'h0);
    hm.lvl(0, 1'h0);
    wt(3);
    rd(8'h04, 32'h10);
    $display("bus reset done");
    bus(1'h1, 8'h0C, 32'h2);
    wt(2);
    chk({clk_en, cur_red}, 32'h2);
    hm.lvl(1, 1'h1);
    wt(3);
    rd(8'h04, 32'h11);
    hm.lvl(2, 1'h1);
    wt(3);
    chk(wake_cpu, 32'h1);
    rd(8'h04, 32'h19);
    hm.lvl(1, 1'h0);
    wt(3);
    rd(8'h04, 32'h18);
    hm.lvl(2, 1'h0);
    wt(3);
    rd(8'h04, 32'h10);
    rd(8'h10, 32'hF);
    wt(1);
    chk(wake_cpu, 32'h0);
    $display("suspend resume done");
    bus(1'h1, 8'h04, 32'h12);
    wt(40);
    chk(wake_n, usb_evt_pkg::WAKE_PULSE_CYC);
    $display("remote wake done");
    end_sim;
  end
endmodule

/* File: usb_evt_checker.sv */
// port checker for the usb event control block
`timescale 1ns/1ns
module usb_evt_checker
(
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  // watched ports
  input wire logic I_BUS_RESET_DET,
  input wire logic I_RESUME_DET,
  input wire logic O_PREADY,
  input wire logic O_REG_EN,
  input wire logic O_REG_TIE_HIGH,
  input wire logic O_USB_MODE,
  input wire logic O_OD_A_OE_N,
  input wire logic O_OD_B_OE_N,
  input wire logic [1:0] O_PULLUP_EN,
  input wire logic O_CPU_RESET,
  input wire logic O_REMOTE_WAKE,
  input wire logic O_WAKE_CPU,
  input wire logic O_USB_IRQ
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SYS_RST);
  // pulse length is counted here, too long to unroll as a repetition
  logic [7:0] wake_len_q;
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST || !O_REMOTE_WAKE)
      wake_len_q <= 8'h00;
    else
      wake_len_q <= wake_len_q + 8'h01;
  end
  sequence bus_reset_held;
    I_BUS_RESET_DET [*2];
  endsequence
  a_cpu_reset_cause: assert property (O_CPU_RESET |-> $past(I_BUS_RESET_DET) || $past(I_BUS_RESET_DET, 2))
    else $error("cpu reset without bus reset");
  a_float_pins: assert property (!O_REG_TIE_HIGH |-> O_OD_A_OE_N && O_OD_B_OE_N && O_PULLUP_EN == 2'h0)
    else $error("pins driven outside open-drain mode");
  a_open_drain_mode: assert property (O_REG_TIE_HIGH |-> O_PULLUP_EN == 2'h3 && !O_REG_EN && !O_USB_MODE)
    else $error("open-drain mode setup wrong");
  a_usb_mode_pins: assert property (O_USB_MODE |-> O_REG_EN && O_OD_A_OE_N && O_OD_B_OE_N)
    else $error("usb mode setup wrong");
  a_resume_wakes_cpu: assert property ($rose(I_RESUME_DET) |-> ##[1:3] O_WAKE_CPU)
    else $error("resume did not wake cpu");
  a_bus_reset_irq: assert property (bus_reset_held |=> O_USB_IRQ)
    else $error("bus reset raised no usb irq");
  a_wake_pulse_len: assert property ($fell(O_REMOTE_WAKE) |-> wake_len_q == 8'(usb_evt_pkg::WAKE_PULSE_CYC))
    else $error("remote wake pulse length wrong");
  a_ready_single: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held over one cycle");
endmodule
bind usb_sie_event_control usb_evt_checker chk
(
  .I_CLOCK(I_CLOCK),
  .I_SYS_RST(I_SYS_RST),
  .I_BUS_RESET_DET(I_BUS_RESET_DET),
  .I_RESUME_DET(I_RESUME_DET),
  .O_PREADY(O_PREADY),
  .O_REG_EN(O_REG_EN),
  .O_REG_TIE_HIGH(O_REG_TIE_HIGH),
  .O_USB_MODE(O_USB_MODE),
  .O_OD_A_OE_N(O_OD_A_OE_N),
  .O_OD_B_OE_N(O_OD_B_OE_N),
  .O_PULLUP_EN(O_PULLUP_EN),
  .O_CPU_RESET(O_CPU_RESET),
  .O_REMOTE_WAKE(O_REMOTE_WAKE),
  .O_WAKE_CPU(O_WAKE_CPU),
  .O_USB_IRQ(O_USB_IRQ)
);

/* File: usb_evt_edge.sv */
// rising-edge pulse detector for one event level
`timescale 1ns/1ns
module usb_evt_edge
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_level,
  output logic o_rise
);
  logic level_q;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      level_q <= 1'b0;
    else if (i_ce)
      level_q <= i_level;
  end

  assign o_rise = i_ce && i_level && !level_q;
endmodule

/* File: usb_evt_pins.sv */
// pin mode decode for regulator and the two shared pins
`timescale 1ns/1ns
module usb_evt_pins
(
  input wire logic [2:0] i_mode,
  input wire logic [1:0] i_od_data,
  output logic o_reg_en,
  output logic o_reg_tie_high,
  output logic o_usb_mode,
  output logic [1:0] o_od_drive_n,
  output logic [1:0] o_pullup_en
);
  always_comb
  begin
    o_reg_en = 1'b0;
    o_reg_tie_high = 1'b0;
    o_usb_mode = 1'b0;
    o_od_drive_n = 2'h3;
    o_pullup_en = 2'h0;
    if (i_mode == usb_evt_pkg::MODE_NONE)
    begin
      o_od_drive_n = 2'h3; // R3
    end
    else if (i_mode == usb_evt_pkg::MODE_OPEN_DRAIN)
    begin
      o_reg_tie_high = 1'b1; // R4
      o_pullup_en = 2'h3; // R4
      o_od_drive_n = i_od_data; // R4
    end
    else if (i_mode[2:1] == usb_evt_pkg::MODE_USB_TOP)
    begin
      o_reg_en = 1'b1; // R5
      o_usb_mode = 1'b1; // R5
    end
    else
    begin
      o_od_drive_n = 2'h3; // R6
    end
  end
endmodule

/* File: usb_evt_pkg.sv */
// constants for the usb event and mode control block
// What this block does
// R1: endpoint enable bits gate endpoint interrupts
// R2: forwarding bit set lets bus reset reset cpu
// R3: mode 000 floats regulator and pins
// R4: mode 001 regulator high, pins open-drain
// R5: mode 01x regulator on, pins usb data
// R6: modes 100-111 leave open-drain pins floating
// R7: resume sets resume flag and wakes cpu
// R8: leaving suspend clears suspend then resume
// R9: firmware enables clock, clears current reduce
// R10: engine alone sets and clears bus reset flag
// R11: remote wake command pulses wake to host
// R12: suspend flag set on suspend, rising edge interrupts
// R13: endpoint access sets flag, interrupts if enabled
// R14: firmware clears endpoint flag after service
package usb_evt_pkg;
  // -------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------
  localparam logic [7:0] OFS_EP_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] OFS_MODE_EVENT = 8'h04;
  localparam logic [7:0] OFS_EP_REQUEST = 8'h08;
  localparam logic [7:0] OFS_CLOCK_CTRL = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // -------------------------------------------------------------
  // mode/event control fields
  // -------------------------------------------------------------
  localparam int BIT_RESET_FWD = 7;
  localparam int BIT_MODE_HI = 6;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_RESUME = 3;
  localparam int BIT_BUS_RESET = 2;
  localparam int BIT_WAKE_CMD = 1;
  localparam int BIT_SUSPEND = 0;
  localparam logic [7:0] RST_MODE_EVENT = 8'h80;
  localparam logic [7:0] RST_EP_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_EP_REQUEST = 8'h00;
  // clock control: bit 1 clock enable, bit 0 current reduce
  localparam int BIT_CLK_EN = 1;
  localparam int BIT_CUR_RED = 0;
  localparam logic [1:0] RST_CLOCK_CTRL = 2'h0;
  // -------------------------------------------------------------
  // irq status layout
  // -------------------------------------------------------------
  localparam int IRQ_EP = 0;
  localparam int IRQ_BUS_RESET = 1;
  localparam int IRQ_SUSPEND = 2;
  localparam int IRQ_RESUME = 3;
  localparam int IRQ_W = 4;
  // -------------------------------------------------------------
  // pin modes
  // -------------------------------------------------------------
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_OPEN_DRAIN = 3'h1;
  localparam logic [1:0] MODE_USB_TOP = 2'h1;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int CLOCK_HZ = 10_000_000;
  localparam int WAKE_PULSE_US = 2;
  localparam int WAKE_PULSE_CYC = (CLOCK_HZ / 1_000_000) * WAKE_PULSE_US;
endpackage

/* File: usb_host_model.sv */
// far-side model: bus events as the serial engine reports them
`timescale 1ns/1ns
module usb_host_model
(
  // clock
  input wire logic i_clk,
  // bus events
  output logic [7:0] o_ep_access,
  output logic o_bus_reset,
  output logic o_suspend,
  output logic o_resume
);
  initial
  begin
    o_ep_access = 8'h00;
    o_bus_reset = 1'h0;
    o_suspend = 1'h0;
    o_resume = 1'h0;
  end
  // one-cycle access strobe; a longer one would look like repeated access
  task automatic hit(input int n);
    @(posedge i_clk);
    o_ep_access <= 8'h01 << n;
    @(posedge i_clk);
    o_ep_access <= 8'h00;
  endtask
  // levels stay until the caller ends the bus condition
  task automatic lvl(input int s, input logic v);
    @(posedge i_clk);
    case (s)
      0: o_bus_reset <= v;
      1: o_suspend <= v;
      default: o_resume <= v;
    endcase
  endtask
endmodule

/* File: usb_sie_event_control.sv */
// usb engine event, mode and endpoint request control with apb registers
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ns
module usb_sie_event_control
#(
  parameter int NUM_EP = 8
)
(
  // clock, reset, enable
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // bus events from the serial engine
  input wire logic [NUM_EP-1:0] I_EP_ACCESS,
  input wire logic I_BUS_RESET_DET,
  input wire logic I_SUSPEND_DET,
  input wire logic I_RESUME_DET,
  input wire logic I_STACK_FULL,
  // data for open-drain mode pins
  input wire logic [1:0] I_OD_DATA,
  // pins, regulator and clock control
  output logic O_REG_EN,
  output logic O_REG_TIE_HIGH,
  output logic O_USB_MODE,
  output logic O_OD_A_OE_N,
  output logic O_OD_B_OE_N,
  output logic [1:0] O_PULLUP_EN,
  output logic O_USB_CLK_EN,
  output logic O_SUSPEND_FLAG_CUR_REDUCE,
  // system effects
  output logic O_CPU_RESET,
  output logic O_REMOTE_WAKE,
  output logic O_WAKE_CPU,
  output logic O_USB_IRQ,
  output logic O_IRQ
);
  logic [7:0] ep_irq_enable_q;
  logic [7:0] mode_ctrl_q;
  logic [NUM_EP-1:0] endpoint_request_flags_q;
  logic [1:0] clk_ctrl_q;
  logic bus_reset_flag_q;
  logic suspend_flag_q;
  logic resume_flag_q;
  logic [usb_evt_pkg::IRQ_W-1:0] irq_status_q;
  logic [usb_evt_pkg::IRQ_W-1:0] irq_mask_q;
  logic [7:0] wake_cnt_q;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic suspend_flag_rise;
  logic rst_rise;
  logic res_rise;
  logic ep_irq;
  logic reg_en;
  logic reg_tie;
  logic usb_mode;
  logic [1:0] od_n;
  logic [1:0] pull_en;
  logic [31:0] rd_data;
  logic [2:0] pin_mode;

  // act once per transfer, in the first access cycle, so the wake strobe and the
  // read clear are not applied a second time in the ready cycle
  assign wr_en = I_CE && I_PSEL && I_PENABLE && !O_PREADY && I_PWRITE;
  assign rd_en = I_CE && I_PSEL && I_PENABLE && !O_PREADY && !I_PWRITE;
  assign pin_mode = mode_ctrl_q[usb_evt_pkg::BIT_MODE_HI:usb_evt_pkg::BIT_MODE_LO];

  // -------------------------------------------------------------
  // edge detectors
  // -------------------------------------------------------------
  usb_evt_edge u_suspend_flag_edge
  (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_ce(I_CE),
    .i_level(suspend_flag_q),
    .o_rise(suspend_flag_rise)
  );

  usb_evt_edge u_rst_edge
  (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_ce(I_CE),
    .i_level(I_BUS_RESET_DET),
    .o_rise(rst_rise)
  );

  usb_evt_edge u_res_edge
  (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_ce(I_CE),
    .i_level(I_RESUME_DET),
    .o_rise(res_rise)
  );

  usb_evt_pins u_pins
  (
    .i_mode(pin_mode),
    .i_od_data(I_OD_DATA),
    .o_reg_en(reg_en),
    .o_reg_tie_high(reg_tie),
    .o_usb_mode(usb_mode),
    .o_od_drive_n(od_n),
    .o_pullup_en(pull_en)
  );

  // -------------------------------------------------------------
  // software registers
  // -------------------------------------------------------------
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      ep_irq_enable_q <= usb_evt_pkg::RST_EP_IRQ_ENABLE; // R1
      mode_ctrl_q <= usb_evt_pkg::RST_MODE_EVENT; // R2
      clk_ctrl_q <= usb_evt_pkg::RST_CLOCK_CTRL;
      irq_mask_q <= '0;
    end
    else if (wr_en)
    begin
      case (I_PADDR)
        usb_evt_pkg::OFS_EP_IRQ_ENABLE: ep_irq_enable_q <= I_PWDATA[7:0];
        usb_evt_pkg::OFS_MODE_EVENT: mode_ctrl_q <= I_PWDATA[7:0];
        usb_evt_pkg::OFS_CLOCK_CTRL: clk_ctrl_q <= I_PWDATA[1:0]; // R9
        usb_evt_pkg::OFS_IRQ_MASK: irq_mask_q <= I_PWDATA[usb_evt_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------
  // endpoint request flags: set wins over software clear
  // -------------------------------------------------------------
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      endpoint_request_flags_q <= usb_evt_pkg::RST_EP_REQUEST;
    else if (I_CE)
    begin
      if (wr_en && I_PADDR == usb_evt_pkg::OFS_EP_REQUEST)
        endpoint_request_flags_q <= I_PWDATA[NUM_EP-1:0] | I_EP_ACCESS; // R14
      else
        endpoint_request_flags_q <= endpoint_request_flags_q | I_EP_ACCESS; // R13
    end
  end

  // -------------------------------------------------------------
  // engine-owned status flags
  // -------------------------------------------------------------
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      bus_reset_flag_q <= 1'b0;
      suspend_flag_q <= 1'b0;
      resume_flag_q <= 1'b0;
    end
    else if (I_CE)
    begin
      bus_reset_flag_q <= I_BUS_RESET_DET; // R10
      suspend_flag_q <= I_SUSPEND_DET; // R12
      // resume clears only once suspend is already low
      if (I_RESUME_DET)
        resume_flag_q <= 1'b1; // R7
      else if (!suspend_flag_q && !I_SUSPEND_DET)
        resume_flag_q <= 1'b0; // R8
    end
  end

  // -------------------------------------------------------------
  // remote wake pulse
  // -------------------------------------------------------------
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      wake_cnt_q <= '0;
    else if (I_CE)
    begin
      if (wr_en && I_PADDR == usb_evt_pkg::OFS_MODE_EVENT && I_PWDATA[usb_evt_pkg::BIT_WAKE_CMD])
        wake_cnt_q <= 8'(usb_evt_pkg::WAKE_PULSE_CYC); // R11
      else if (wake_cnt_q != '0)
        wake_cnt_q <= wake_cnt_q - 8'h01;
    end
  end

  // -------------------------------------------------------------
  // interrupt status: set wins over read clear
  // -------------------------------------------------------------
  logic [usb_evt_pkg::IRQ_W-1:0] irq_set;
  always_comb
  begin
    irq_set = '0;
    irq_set[usb_evt_pkg::IRQ_EP] = |(I_EP_ACCESS & ep_irq_enable_q[NUM_EP-1:0]); // R1
    irq_set[usb_evt_pkg::IRQ_BUS_RESET] = rst_rise; // R10
    irq_set[usb_evt_pkg::IRQ_SUSPEND] = suspend_flag_rise; // R12
    irq_set[usb_evt_pkg::IRQ_RESUME] = res_rise; // R7
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      irq_status_q <= '0;
    else if (I_CE)
    begin
      if (rd_en && I_PADDR == usb_evt_pkg::OFS_IRQ_STATUS)
        irq_status_q <= irq_set;
      else
        irq_status_q <= irq_status_q | irq_set;
    end
  end

  assign ep_irq = |(endpoint_request_flags_q & ep_irq_enable_q[NUM_EP-1:0]) && !I_STACK_FULL; // R13

  // -------------------------------------------------------------
  // read mux
  // -------------------------------------------------------------
  always_comb
  begin
    rd_data = '0;
    mapped = 1'b1;
    case (I_PADDR)
      usb_evt_pkg::OFS_EP_IRQ_ENABLE: rd_data[7:0] = ep_irq_enable_q;
      usb_evt_pkg::OFS_MODE_EVENT:
      begin
        rd_data[usb_evt_pkg::BIT_RESET_FWD] = mode_ctrl_q[usb_evt_pkg::BIT_RESET_FWD];
        rd_data[usb_evt_pkg::BIT_MODE_HI:usb_evt_pkg::BIT_MODE_LO] = pin_mode;
        rd_data[usb_evt_pkg::BIT_RESUME] = resume_flag_q;
        rd_data[usb_evt_pkg::BIT_BUS_RESET] = bus_reset_flag_q;
        rd_data[usb_evt_pkg::BIT_WAKE_CMD] = (wake_cnt_q != '0);
        rd_data[usb_evt_pkg::BIT_SUSPEND] = suspend_flag_q;
      end
      usb_evt_pkg::OFS_EP_REQUEST: rd_data[NUM_EP-1:0] = endpoint_request_flags_q;
      usb_evt_pkg::OFS_CLOCK_CTRL: rd_data[1:0] = clk_ctrl_q;
      usb_evt_pkg::OFS_IRQ_STATUS: rd_data[usb_evt_pkg::IRQ_W-1:0] = irq_status_q;
      usb_evt_pkg::OFS_IRQ_MASK: rd_data[usb_evt_pkg::IRQ_W-1:0] = irq_mask_q;
      default: mapped = 1'b0;
    endcase
  end

  // -------------------------------------------------------------
  // registered outputs
  // -------------------------------------------------------------
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      O_PRDATA <= '0;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end
    else if (I_CE)
    begin
      // one wait state: ready rises in the second access cycle
      O_PREADY <= I_PSEL && I_PENABLE && !O_PREADY;
      O_PSLVERR <= I_PSEL && I_PENABLE && !O_PREADY && !mapped;
      O_PRDATA <= (I_PSEL && !I_PWRITE) ? rd_data : '0;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      O_REG_EN <= 1'b0;
      O_REG_TIE_HIGH <= 1'b0;
      O_USB_MODE <= 1'b0;
      O_OD_A_OE_N <= 1'b1;
      O_OD_B_OE_N <= 1'b1;
      O_PULLUP_EN <= 2'h0;
      O_USB_CLK_EN <= 1'b0;
      O_SUSPEND_FLAG_CUR_REDUCE <= 1'b0;
      O_CPU_RESET <= 1'b0;
      O_REMOTE_WAKE <= 1'b0;
      O_WAKE_CPU <= 1'b0;
      O_USB_IRQ <= 1'b0;
      O_IRQ <= 1'b0;
    end
    else if (I_CE)
    begin
      O_REG_EN <= reg_en;
      O_REG_TIE_HIGH <= reg_tie;
      O_USB_MODE <= usb_mode;
      O_OD_A_OE_N <= od_n[0];
      O_OD_B_OE_N <= od_n[1];
      O_PULLUP_EN <= pull_en;
      O_USB_CLK_EN <= clk_ctrl_q[usb_evt_pkg::BIT_CLK_EN];
      O_SUSPEND_FLAG_CUR_REDUCE <= clk_ctrl_q[usb_evt_pkg::BIT_CUR_RED];
      O_CPU_RESET <= mode_ctrl_q[usb_evt_pkg::BIT_RESET_FWD] && I_BUS_RESET_DET; // R2
      O_REMOTE_WAKE <= (wake_cnt_q != '0); // R11
      O_WAKE_CPU <= irq_status_q[usb_evt_pkg::IRQ_RESUME]; // R7
      O_USB_IRQ <= ep_irq || bus_reset_flag_q; // R10
      O_IRQ <= |(irq_status_q & irq_mask_q);
    end
  end
endmodule
